// ===== rtl/crdb_pkg.sv
// package for the coefficient bank double-buffer controller
package crdb_pkg;
  localparam logic [7:0] CRDB_BANK_CTRL_ADDR = 8'h01;   // coeff_bank_control offset
  localparam int         CRDB_BIT_MONITOR    = 3;
  localparam int         CRDB_BIT_ADAPTIVE   = 2;
  localparam int         CRDB_BIT_ACTIVE     = 1;
  localparam int         CRDB_BIT_SWITCH     = 0;
  localparam logic       CRDB_ADAPTIVE_RST   = 1'b0;
  localparam logic       CRDB_SWITCH_RST     = 1'b0;
  localparam logic       CRDB_BANK_A         = 1'b0;
  localparam logic       CRDB_BANK_B         = 1'b1;
  localparam logic [7:0] CRDB_ZERO_BYTE      = 8'h00;

  // register port request from the serial control port
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } crdb_reg_req_t;

  // per-bank grant pair
  typedef struct packed {
    logic bankA;
    logic bankB;
  } crdb_grant_t;

  typedef enum logic [1:0] {
    CRDB_IDLE,
    CRDB_WAIT_PASS,
    CRDB_DONE
  } crdb_state_t;
endpackage : crdb_pkg

// ===== rtl/crdb_coeff_bank_ctrl.sv
// coefficient bank access arbiter and double-buffer swap control
`timescale 1ns/1ps

// Summary of operation
// - with adaptive mode off, bit 3 shows the bank the processor uses, 0 for A and 1 for B.
// - with adaptive mode on, bit 3 carries no meaning and software must not rely on it.
// - bit 2 is a read/write adaptive mode enable that resets to 0.
// - adaptive mode with the processor stopped grants the serial port bank A only.
// - adaptive mode with the processor running gives the active bank to it and the other to the serial port.
// - adaptive mode off with the processor stopped lets the serial port reach both banks.
// - adaptive mode off with the processor running blocks serial access to both banks.
// - adaptive mode off lets the processor read either bank and bit 3 reflects the one in use.
// - bit 1 is a read-only flag naming the active bank.
// - in adaptive mode with the processor running, the bank that is not active is the update buffer, writable from the serial port.
// - bit 1 reads 0 when bank A is active and 1 when bank B is active.
// - the device clears bit 0 itself once the exchange is finished.
module crdb_coeff_bank_ctrl
  import crdb_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          clkEn,
  input  wire crdb_reg_req_t regReq,
  input  wire logic          dspRun,
  input  wire logic          dspPassStart,
  input  wire logic          dspBankSel,
  output      logic [7:0]    regRdData,
  output      logic          regRdValid,
  output      crdb_grant_t   hostGrant,
  output      logic          dspBank,
  output      logic          activeBank
);


  // control, status and sequencer state
  logic        adaptiveMode;
  logic        switchReq;
  logic        monitorBank;
  crdb_state_t state;
  crdb_state_t next_state;

  // field positions must sit inside the control byte
  if (CRDB_BIT_MONITOR >= $bits(regRdData)) begin : g_bad_monitor_field
    $error("monitor field outside the control byte");
  end
  if (CRDB_BIT_ADAPTIVE >= $bits(regRdData)) begin : g_bad_adaptive_field
    $error("adaptive field outside the control byte");
  end
  if (CRDB_BIT_ACTIVE >= $bits(regRdData)) begin : g_bad_active_field
    $error("active field outside the control byte");
  end
  if (CRDB_BIT_SWITCH >= $bits(regRdData)) begin : g_bad_switch_field
    $error("switch field outside the control byte");
  end
  // the two bank codes must be told apart
  if (CRDB_BANK_A == CRDB_BANK_B) begin : g_bad_bank_codes
    $error("bank codes must differ");
  end

  // bank that is active once a pending exchange has been applied
  function automatic logic bankAfter(input logic act, input logic swap);
    logic b;
    b = act;
    if (swap) begin
      b = ~act;
    end
    return b;
  endfunction : bankAfter

  // control byte as the host reads it, reserved bits zero
  function automatic logic [7:0] packCtrl(input logic mon, input logic adp, input logic act, input logic sw);
    logic [7:0] b;
    b                    = CRDB_ZERO_BYTE;
    b[CRDB_BIT_MONITOR]  = mon;
    b[CRDB_BIT_ADAPTIVE] = adp;
    b[CRDB_BIT_ACTIVE]   = act;
    b[CRDB_BIT_SWITCH]   = sw;
    return b;
  endfunction : packCtrl

  // register decode
  wire logic   hitCtrl     = (regReq.addr == CRDB_BANK_CTRL_ADDR);
  wire logic   ctrlWrite   = clkEn && regReq.wrEn && hitCtrl;
  wire logic   ctrlRead    = clkEn && regReq.rdEn;
  wire logic   hostSetSw   = ctrlWrite && regReq.wrData[CRDB_BIT_SWITCH];
  wire logic   hostMode    = regReq.wrData[CRDB_BIT_ADAPTIVE];

  // pass boundary and exchange timing
  wire logic   passEdge    = dspPassStart || !dspRun;
  wire logic   swapNow     = (state == CRDB_WAIT_PASS) && passEdge;
  wire logic   swapDone    = (state == CRDB_DONE);
  wire logic   bankNext    = bankAfter(activeBank, swapNow);

  // bank the processor draws from: active bank in adaptive mode, its own choice otherwise
  wire logic   next_dspBank = adaptiveMode ? bankNext : dspBankSel;
  // monitor mirrors the processor bank; meaningless while adaptive mode is on
  wire logic   next_monitorBank = next_dspBank;

  // control flop next values, a host set beats the sequencer clear
  wire logic   next_adaptiveMode = ctrlWrite ? hostMode : adaptiveMode;
  wire logic   next_switchReq    = hostSetSw ? 1'b1 : (swapDone ? 1'b0 : switchReq);
  wire logic   next_activeBank   = bankNext;

  // serial port grants per mode and processor state
  function automatic crdb_grant_t grantOf(input logic adp, input logic run, input logic act);
    crdb_grant_t g;
    g = '0;
    if (adp && !run) begin
      g.bankA = 1'b1;
    end else if (adp && run) begin
      g.bankA = (act == CRDB_BANK_B);
      g.bankB = (act == CRDB_BANK_A);
    end else if (!adp && !run) begin
      g.bankA = 1'b1;
      g.bankB = 1'b1;
    end
    return g;
  endfunction : grantOf

  // grants follow the bank that will be active after this edge
  wire crdb_grant_t next_hostGrant = grantOf(adaptiveMode, dspRun, bankNext);

  // readback byte, unmapped addresses read zero, held between reads
  wire logic [7:0] ctrlByte    = packCtrl(monitorBank, adaptiveMode, activeBank, switchReq);
  wire logic [7:0] mappedData  = hitCtrl ? ctrlByte : CRDB_ZERO_BYTE;
  wire logic [7:0] next_rdData = ctrlRead ? mappedData : regRdData;

  // swap sequencer
  always_comb begin
    next_state = state;
    case (state)
      CRDB_IDLE:      if (switchReq) next_state = CRDB_WAIT_PASS;
      CRDB_WAIT_PASS: if (swapNow) next_state = CRDB_DONE;
      CRDB_DONE:      next_state = CRDB_IDLE;
      default:        next_state = CRDB_IDLE;
    endcase
  end

  // swap sequencer state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= CRDB_IDLE;
    end else if (clkEn) begin
      state <= next_state;
    end
  end

  // adaptive mode enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adaptiveMode <= CRDB_ADAPTIVE_RST;
    end else if (clkEn) begin
      adaptiveMode <= next_adaptiveMode;
    end
  end

  // exchange request flag, set by host, cleared when done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      switchReq <= CRDB_SWITCH_RST;
    end else if (clkEn) begin
      switchReq <= next_switchReq;
    end
  end

  // active bank, toggled only at a pass boundary or while the processor is stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      activeBank <= CRDB_BANK_A;
    end else if (clkEn) begin
      activeBank <= next_activeBank;
    end
  end

  // in-use bank monitor
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      monitorBank <= CRDB_BANK_A;
    end else if (clkEn) begin
      monitorBank <= next_monitorBank;
    end
  end

  // read port, one valid pulse per read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData  <= CRDB_ZERO_BYTE;
      regRdValid <= 1'b0;
    end else if (clkEn) begin
      regRdData  <= next_rdData;
      regRdValid <= ctrlRead;
    end
  end

  // bank access outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hostGrant <= '0;
      dspBank   <= CRDB_BANK_A;
    end else if (clkEn) begin
      hostGrant <= next_hostGrant;
      dspBank   <= next_dspBank;
    end
  end

  // checks
  a_swap_clears_request: assert property (@(posedge clk) disable iff (rst)
    (clkEn && swapNow && !hostSetSw) ##1 (clkEn && !hostSetSw) |=> !switchReq)
    else $error("switch request not cleared after swap");
  a_swap_waits_pass: assert property (@(posedge clk) disable iff (rst)
    (clkEn && $changed(activeBank)) |-> $past(dspPassStart || !dspRun))
    else $error("bank swapped mid pass");
  a_run_blocks_host: assert property (@(posedge clk) disable iff (rst)
    (clkEn && !adaptiveMode && dspRun) |=> (hostGrant == '0))
    else $error("host granted while processor runs");
  a_stop_grants_both: assert property (@(posedge clk) disable iff (rst)
    (clkEn && !adaptiveMode && !dspRun) |=> (hostGrant.bankA && hostGrant.bankB))
    else $error("host not granted both banks");
  a_adaptive_stop_a: assert property (@(posedge clk) disable iff (rst)
    (clkEn && adaptiveMode && !dspRun) |=> (hostGrant.bankA && !hostGrant.bankB))
    else $error("adaptive standby must grant bank A only");
  a_adaptive_exclusive: assert property (@(posedge clk) disable iff (rst)
    (clkEn && adaptiveMode && dspRun && !swapNow)
      |=> (dspBank == activeBank) && (hostGrant.bankB == (activeBank == CRDB_BANK_A)))
    else $error("adaptive banks not exclusive");
  a_monitor_follows: assert property (@(posedge clk) disable iff (rst)
    (clkEn && !adaptiveMode) |=> (monitorBank == $past(dspBankSel)))
    else $error("monitor does not follow processor bank");
  a_mode_reset_zero: assert property (@(posedge clk)
    rst |=> (adaptiveMode == CRDB_ADAPTIVE_RST))
    else $error("adaptive mode not zero after reset");
  a_read_active_bit: assert property (@(posedge clk) disable iff (rst)
    (ctrlRead && hitCtrl) |=> (regRdData[CRDB_BIT_ACTIVE] == $past(activeBank)))
    else $error("active bank readback wrong");

  // read port handshake
  a_read_gives_valid: assert property (@(posedge clk) disable iff (rst)
    ctrlRead |=> regRdValid)
    else $error("read strobe gave no valid pulse");
  a_valid_one_pulse: assert property (@(posedge clk) disable iff (rst)
    (clkEn && !ctrlRead) |=> !regRdValid)
    else $error("valid without read strobe");
  a_unmapped_reads_zero: assert property (@(posedge clk) disable iff (rst)
    (ctrlRead && !hitCtrl) |=> (regRdData == CRDB_ZERO_BYTE))
    else $error("unmapped read not zero");

  // control flags
  a_write_sets_mode: assert property (@(posedge clk) disable iff (rst)
    ctrlWrite |=> (adaptiveMode == $past(regReq.wrData[CRDB_BIT_ADAPTIVE])))
    else $error("adaptive mode write lost");
  a_request_sets_flag: assert property (@(posedge clk) disable iff (rst)
    hostSetSw |=> switchReq)
    else $error("switch request not latched");
  a_done_one_cycle: assert property (@(posedge clk) disable iff (rst)
    (clkEn && swapDone) |=> (state == CRDB_IDLE))
    else $error("done state held too long");
  a_standby_swaps_now: assert property (@(posedge clk) disable iff (rst)
    (clkEn && (state == CRDB_WAIT_PASS) && !dspRun) |=> (activeBank != $past(activeBank)))
    else $error("swap not taken in standby");

  // update buffer is the bank the processor does not use
  a_update_bank_host: assert property (@(posedge clk) disable iff (rst)
    (clkEn && adaptiveMode && dspRun)
      |=> (hostGrant.bankA == (dspBank == CRDB_BANK_B)) && (hostGrant.bankB == (dspBank == CRDB_BANK_A)))
    else $error("update bank not given to host");

  // clock enable low freezes all state
  a_freeze_holds: assert property (@(posedge clk) disable iff (rst)
    !clkEn |=> ($stable(adaptiveMode) && $stable(activeBank) && $stable(switchReq) && $stable(hostGrant)))
    else $error("state moved while clock enable low");

endmodule : crdb_coeff_bank_ctrl

// ===== test/crdb_host_model.sv
// host-side register master for the bank controller
`timescale 1ns/1ps
module crdb_host_model
  import crdb_pkg::*;
(
  input  wire logic          clk,
  output      crdb_reg_req_t regReq,
  input  wire logic [7:0]    regRdData,
  input  wire logic          regRdValid
);
  initial regReq = '0;
  // one write strobe per byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(posedge clk) #1;
    regReq.wrEn = 1'b0;
  endtask : wr
  // read strobe, byte taken with the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk) #1;
    regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    @(posedge clk) #1;
    regReq.rdEn = 1'b0;
    v = regRdValid;
    d = regRdData;
  endtask : rd
endmodule : crdb_host_model

// ===== test/tb_coeff_ram_double_buffer.sv
// self-checking bench for the coefficient bank controller
`timescale 1ns/1ps
module tb_coeff_ram_double_buffer;
  import crdb_pkg::*;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          clkEn = 1'b1;
  logic          dspRun = 1'b0;
  logic          dspPassStart = 1'b0;
  logic          dspBankSel = 1'b0;
  crdb_reg_req_t regReq;
  logic [7:0]    regRdData;
  logic          regRdValid;
  crdb_grant_t   hostGrant;
  logic          dspBank;
  logic          activeBank;
  int            fails = 0;
  int            compares = 0;
  logic [7:0]    rdByte;
  logic          rdOk;
  // adaptive, run, bank select | grant A, grant B, processor bank
  logic [5:0]    rows [6] = '{6'b000110, 6'b001111, 6'b010000, 6'b011001, 6'b101100, 6'b111010};
  always #10 clk = ~clk;
  crdb_coeff_bank_ctrl crdb_coeff_bank_ctrl_inst (.clk(clk), .rst(rst), .clkEn(clkEn), .regReq(regReq),
    .dspRun(dspRun), .dspPassStart(dspPassStart), .dspBankSel(dspBankSel), .regRdData(regRdData),
    .regRdValid(regRdValid), .hostGrant(hostGrant), .dspBank(dspBank), .activeBank(activeBank));
  crdb_host_model crdb_host_model_inst (.clk(clk), .regReq(regReq), .regRdData(regRdData),
    .regRdValid(regRdValid));
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // control byte read, masked where undefined
  task automatic rd_chk(input logic [7:0] mask, input logic [7:0] exp);
    crdb_host_model_inst.rd(CRDB_BANK_CTRL_ADDR, rdByte, rdOk);
    chk("regRdValid", 8'h01, {7'h00, rdOk});
    chk("regRdData", exp, rdByte & mask);
  endtask : rd_chk
  task automatic tally_and_finish();
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // watchdog
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    rd_chk(8'hFF, 8'h00);
    foreach (rows[i]) begin
      crdb_host_model_inst.wr(CRDB_BANK_CTRL_ADDR, {5'h00, rows[i][5], 2'b00});
      {dspRun, dspBankSel} = rows[i][4:3];
      repeat (3) @(posedge clk);
      #1 chk("hostGrant", {6'h00, rows[i][2:1]}, {6'h00, hostGrant});
      chk("dspBank", {7'h00, rows[i][0]}, {7'h00, dspBank});
      rd_chk(rows[i][5] ? 8'hF7 : 8'hFF, {4'h0, ~rows[i][5] & rows[i][3], rows[i][5], 2'b00});
    end
    // swap held off until a pass boundary
    crdb_host_model_inst.wr(CRDB_BANK_CTRL_ADDR, 8'h05);
    repeat (4) @(posedge clk);
    rd_chk(8'hF7, 8'h05);
    chk("activeBank", 8'h00, {7'h00, activeBank});
    @(posedge clk) #1 dspPassStart = 1'b1;
    @(posedge clk) #1 dspPassStart = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("activeBank", 8'h01, {7'h00, activeBank});
    chk("dspBank", 8'h01, {7'h00, dspBank});
    chk("hostGrant", 8'h02, {6'h00, hostGrant});
    rd_chk(8'hF7, 8'h06);
    // unmapped address
    crdb_host_model_inst.wr(8'h02, 8'h00);
    crdb_host_model_inst.rd(8'h02, rdByte, rdOk);
    chk("unmappedRead", 8'h00, rdByte);
    rd_chk(8'hF7, 8'h06);
    // clock enable low: the write must be ignored
    clkEn = 1'b0;
    crdb_host_model_inst.wr(CRDB_BANK_CTRL_ADDR, 8'h00);
    clkEn = 1'b1;
    rd_chk(8'hF7, 8'h06);
    // reset in mid-run
    @(posedge clk) #1 rst = 1'b1;
    dspBankSel = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk("activeBank", 8'h00, {7'h00, activeBank});
    rd_chk(8'hFF, 8'h08);
    tally_and_finish();
  end
endmodule : tb_coeff_ram_double_buffer
